// ### core/bram_pkg.sv
// Purpose: shared constants and types of the dual-port block memory
// Assumes: one 36864-bit array, splittable into two 18432-bit halves
// Notes: widths and depths are defaults for the top module parameters
package bram_pkg;

	localparam int CAP_BITS = 36864;
	localparam int HALF_BITS = 18432;
	localparam int DEF_DATA_W = 36;
	localparam int DEF_DEPTH = 1024;
	localparam int NUM_PORTS = 2;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;

	typedef enum logic [2:0] {
		WM_READ_FIRST = 3'h1,
		WM_WRITE_FIRST = 3'h2,
		WM_NO_CHANGE = 3'h4
	} wmode_t;

	localparam wmode_t DEF_WMODE = WM_READ_FIRST;
	localparam logic DEF_ADDR_LATCH = 1'b1;
	localparam logic DEF_OUT_REG = 1'b0;
	localparam logic DEF_SPLIT = 1'b0;

endpackage

// ### core/bram_out_stage.sv
// Purpose: output stage of one memory port, cascade select and pipeline
// Assumes: inputs come from flops on core_clk
// Notes: OUT_REG adds one register stage after the output register
`timescale 1ns/1ps

module bram_out_stage #(
	parameter int DATA_W = 36,
	parameter logic OUT_REG = 1'b0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sel_cas,
	input wire logic load,
	input wire logic [DATA_W-1:0] local_data,
	input wire logic [DATA_W-1:0] cas_data,
	output logic [DATA_W-1:0] dout
);

	logic [DATA_W-1:0] out_q;
	logic [DATA_W-1:0] pipe_q;

	// output register, held while no new read data arrives
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			out_q <= '0;
		end else if (load) begin
			out_q <= sel_cas ? cas_data : local_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pipe_q <= '0;
		end else begin
			pipe_q <= out_q;
		end
	end

	generate
		if (OUT_REG) begin : g_pipe
			assign dout = pipe_q;
		end else begin : g_nopipe
			assign dout = out_q;
		end
	endgenerate

endmodule

// ### core/true_dual_port_block_ram.sv
// Purpose: true dual-port block memory with cascade and power gating
// Assumes: both ports run on core_clk; memory contents are not reset
// Notes: same-address writes from both ports leave port B's word
//
// How it works
// - two independent ports sharing only the stored contents
// - one full array, or two independent half-size arrays
// - every read and write happens on a clock edge
// - data, address, enable and write enable are registered first
// - captured address held until next access unless latching is off
// - optional output pipeline adds one cycle of read latency
// - write output policy: old word, new word, or unchanged
// - cascade links pass requests to the adjacent block and take its read data
// - a power gating input stops all access to the block
`timescale 1ns/1ps

module true_dual_port_block_ram
	import bram_pkg::*;
#(
	parameter int DATA_W = bram_pkg::DEF_DATA_W,
	parameter int DEPTH = bram_pkg::DEF_DEPTH,
	parameter logic SPLIT = bram_pkg::DEF_SPLIT,
	parameter logic ADDR_LATCH = bram_pkg::DEF_ADDR_LATCH,
	parameter logic OUT_REG = bram_pkg::DEF_OUT_REG,
	parameter bram_pkg::wmode_t WMODE_A = bram_pkg::DEF_WMODE,
	parameter bram_pkg::wmode_t WMODE_B = bram_pkg::DEF_WMODE,
	parameter int ADDR_W = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic power_gate,
	input wire logic a_en,
	input wire logic a_we,
	input wire logic a_cas_sel,
	input wire logic [ADDR_W-1:0] a_addr,
	input wire logic [DATA_W-1:0] a_wdata,
	output logic [DATA_W-1:0] a_rdata,
	input wire logic b_en,
	input wire logic b_we,
	input wire logic b_cas_sel,
	input wire logic [ADDR_W-1:0] b_addr,
	input wire logic [DATA_W-1:0] b_wdata,
	output logic [DATA_W-1:0] b_rdata,
	input wire logic [DATA_W-1:0] a_cas_in_rdata,
	input wire logic [DATA_W-1:0] b_cas_in_rdata,
	output logic a_cas_out_en,
	output logic a_cas_out_we,
	output logic [ADDR_W-1:0] a_cas_out_addr,
	output logic [DATA_W-1:0] a_cas_out_wdata,
	output logic b_cas_out_en,
	output logic b_cas_out_we,
	output logic [ADDR_W-1:0] b_cas_out_addr,
	output logic [DATA_W-1:0] b_cas_out_wdata
);

	// depth clipped to what the array size holds
	localparam int ARR_BITS = SPLIT ? HALF_BITS : CAP_BITS;
	localparam int MAX_DEPTH = ARR_BITS / DATA_W;
	localparam int USE_DEPTH = (DEPTH < MAX_DEPTH) ? DEPTH : MAX_DEPTH;
	localparam int HALF_W = (USE_DEPTH > 1) ? $clog2(USE_DEPTH) : 1;
	localparam int MEM_W = HALF_W + 1;
	localparam int MEM_DEPTH = 2 * USE_DEPTH;

	logic [DATA_W-1:0] mem [MEM_DEPTH];

	logic [NUM_PORTS-1:0] in_en;
	logic [NUM_PORTS-1:0] in_we;
	logic [NUM_PORTS-1:0] in_cas;
	logic [ADDR_W-1:0] in_addr [NUM_PORTS];
	logic [DATA_W-1:0] in_wdata [NUM_PORTS];
	logic [DATA_W-1:0] cas_in [NUM_PORTS];

	logic [NUM_PORTS-1:0] en_q;
	logic [NUM_PORTS-1:0] we_q;
	logic [NUM_PORTS-1:0] cas_q;
	logic [ADDR_W-1:0] addr_q [NUM_PORTS];
	logic [DATA_W-1:0] wdata_q [NUM_PORTS];

	logic [NUM_PORTS-1:0] act;
	logic [NUM_PORTS-1:0] wr;
	logic [MEM_W-1:0] mem_addr [NUM_PORTS];

	logic [DATA_W-1:0] rd_q [NUM_PORTS];
	logic [NUM_PORTS-1:0] rd_load;
	logic [NUM_PORTS-1:0] rd_cas;
	logic [DATA_W-1:0] dout [NUM_PORTS];
	wmode_t wmode [NUM_PORTS];

	assign in_en = {b_en, a_en};
	assign in_we = {b_we, a_we};
	assign in_cas = {b_cas_sel, a_cas_sel};
	assign in_addr[PORT_A] = a_addr;
	assign in_addr[PORT_B] = b_addr;
	assign in_wdata[PORT_A] = a_wdata;
	assign in_wdata[PORT_B] = b_wdata;
	assign cas_in[PORT_A] = a_cas_in_rdata;
	assign cas_in[PORT_B] = b_cas_in_rdata;
	assign wmode[PORT_A] = WMODE_A;
	assign wmode[PORT_B] = WMODE_B;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					en_q[p] <= 1'b0;
					we_q[p] <= 1'b0;
					cas_q[p] <= 1'b0;
					wdata_q[p] <= '0;
				end else begin
					en_q[p] <= in_en[p] & ~power_gate;
					we_q[p] <= in_we[p];
					cas_q[p] <= in_cas[p];
					wdata_q[p] <= in_wdata[p];
				end
			end

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					addr_q[p] <= '0;
				end else if (!ADDR_LATCH || (in_en[p] && !power_gate)) begin
					addr_q[p] <= in_addr[p];
				end
			end

			assign act[p] = en_q[p] & ~cas_q[p] & ~power_gate;
			assign wr[p] = act[p] & we_q[p];

			// split mode gives each port its own half
			assign mem_addr[p] = SPLIT ?
				{p[0], addr_q[p][HALF_W-1:0]} :
				{1'b0, addr_q[p][HALF_W-1:0]};

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					rd_q[p] <= '0;
				end else if (act[p]) begin
					if (!we_q[p]) begin
						rd_q[p] <= mem[mem_addr[p]];
					end else begin
						case (wmode[p])
							WM_READ_FIRST: begin
								rd_q[p] <= mem[mem_addr[p]];
							end
							WM_WRITE_FIRST: begin
								rd_q[p] <= wdata_q[p];
							end
							WM_NO_CHANGE: begin
								rd_q[p] <= rd_q[p];
							end
							default: begin
								rd_q[p] <= rd_q[p];
							end
						endcase
					end
				end
			end

			// load strobe aligned with read data; local no-change writes skip it, cascade writes still load
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					rd_load[p] <= 1'b0;
					rd_cas[p] <= 1'b0;
				end else begin
					rd_load[p] <= en_q[p] & ~power_gate &
						~(we_q[p] & ~cas_q[p] & (wmode[p] == WM_NO_CHANGE));
					rd_cas[p] <= cas_q[p];
				end
			end

			bram_out_stage #(
				.DATA_W(DATA_W),
				.OUT_REG(OUT_REG)
			) u_out (
				.core_clk(core_clk),
				.rstn(rstn),
				.sel_cas(rd_cas[p]),
				.load(rd_load[p]),
				.local_data(rd_q[p]),
				.cas_data(cas_in[p]),
				.dout(dout[p])
			);
		end
	endgenerate

	// shared array, ports collide only in storage
	always_ff @(posedge core_clk) begin
		if (wr[PORT_A]) begin
			mem[mem_addr[PORT_A]] <= wdata_q[PORT_A];
		end
		if (wr[PORT_B]) begin
			mem[mem_addr[PORT_B]] <= wdata_q[PORT_B];
		end
	end

	// cascade request forwarding to adjacent block
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			a_cas_out_en <= 1'b0;
			a_cas_out_we <= 1'b0;
			a_cas_out_addr <= '0;
			a_cas_out_wdata <= '0;
			b_cas_out_en <= 1'b0;
			b_cas_out_we <= 1'b0;
			b_cas_out_addr <= '0;
			b_cas_out_wdata <= '0;
		end else begin
			a_cas_out_en <= a_en & a_cas_sel & ~power_gate;
			a_cas_out_we <= a_we;
			a_cas_out_addr <= a_addr;
			a_cas_out_wdata <= a_wdata;
			b_cas_out_en <= b_en & b_cas_sel & ~power_gate;
			b_cas_out_we <= b_we;
			b_cas_out_addr <= b_addr;
			b_cas_out_wdata <= b_wdata;
		end
	end

	assign a_rdata = dout[PORT_A];
	assign b_rdata = dout[PORT_B];

endmodule

// ### verification/tdp_props.sv
// Purpose: port properties of the dual-port memory
// Assumes: read-first, no output register
// Notes: bound to the memory top
`timescale 1ns/1ps
module tdp_props #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 10
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic power_gate,
	input wire logic a_en,
	input wire logic a_cas_sel,
	input wire logic [ADDR_W-1:0] a_addr,
	input wire logic [DATA_W-1:0] a_rdata,
	input wire logic b_en,
	input wire logic b_cas_sel,
	input wire logic [DATA_W-1:0] b_rdata,
	input wire logic a_cas_out_en,
	input wire logic [ADDR_W-1:0] a_cas_out_addr,
	input wire logic b_cas_out_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire a_req = a_en && a_cas_sel && !power_gate;
	wire b_req = b_en && b_cas_sel && !power_gate;
	a_cas_fwd: assert property (a_req |=> a_cas_out_en)
		else $error("A cascade lost");
	a_cas_quiet: assert property (!a_req |=> !a_cas_out_en)
		else $error("A cascade spurious");
	a_b_cas_fwd: assert property (b_req |=> b_cas_out_en)
		else $error("B cascade lost");
	a_b_cas_quiet: assert property (!b_req |=> !b_cas_out_en)
		else $error("B cascade spurious");
	a_cas_addr: assert property (a_req |=>
		a_cas_out_addr == $past(a_addr)) else $error("A cascade address");
	a_gate_hold: assert property ($past(power_gate, 2) &&
		$past(power_gate) |-> $stable(a_rdata)) else $error("gated change");
	a_rd_cause: assert property ($changed(a_rdata) |->
		$past(a_en, 3)) else $error("A data without request");
	a_b_rd_cause: assert property ($changed(b_rdata) |->
		$past(b_en, 3)) else $error("B data without request");
	cover property (a_req);
	cover property (b_req);
	cover property (power_gate && b_en);
endmodule

bind true_dual_port_block_ram tdp_props #(.DATA_W(DATA_W),
	.ADDR_W(ADDR_W)) u_props (.*);

// ### verification/cas_neighbour.sv
// Purpose: adjacent block answering cascade requests
// Assumes: answer sampled one edge after the request
// Notes: idle output inverts each cycle so data sampled one edge late differs
`timescale 1ns/1ps
module cas_neighbour (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic we,
	input wire logic [9:0] addr,
	input wire logic [35:0] wdata,
	output logic [35:0] rdata
);
	logic [35:0] mem [1024];
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata <= 36'h0;
		end else if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end else begin
			rdata <= ~rdata;
		end
	end
endmodule

// ### verification/testbench.sv
// Purpose: scenario bench for the dual-port memory
// Assumes: default widths, port B write-first, no output register
// Notes: data checked at the fixed read latency
`timescale 1ns/1ps
module testbench;
	import bram_pkg::*;
	logic core_clk, rstn, power_gate;
	logic [1:0] en, we, cs;
	wire [1:0] co_en, co_we;
	logic [9:0] ad [2];
	wire [9:0] co_ad [2];
	logic [35:0] wd [2];
	wire [35:0] rd [2];
	wire [35:0] co_wd [2];
	wire [35:0] ci [2];
	int fail_count, checked;
	localparam logic [9:0] X = 10'h3FF;
	true_dual_port_block_ram #(.WMODE_B(WM_WRITE_FIRST))
		DUT (.core_clk(core_clk), .rstn(rstn),
		.power_gate(power_gate), .a_en(en[0]), .a_we(we[0]),
		.a_cas_sel(cs[0]), .a_addr(ad[0]), .a_wdata(wd[0]), .a_rdata(rd[0]),
		.b_en(en[1]), .b_we(we[1]), .b_cas_sel(cs[1]), .b_addr(ad[1]),
		.b_wdata(wd[1]), .b_rdata(rd[1]), .a_cas_in_rdata(ci[0]),
		.b_cas_in_rdata(ci[1]), .a_cas_out_en(co_en[0]),
		.a_cas_out_we(co_we[0]), .a_cas_out_addr(co_ad[0]),
		.a_cas_out_wdata(co_wd[0]), .b_cas_out_en(co_en[1]),
		.b_cas_out_we(co_we[1]), .b_cas_out_addr(co_ad[1]),
		.b_cas_out_wdata(co_wd[1]));
	for (genvar i = 0; i < 2; i++) begin : g_nb
		cas_neighbour nb (.core_clk(core_clk), .rstn(rstn), .en(co_en[i]),
			.we(co_we[i]), .addr(co_ad[i]), .wdata(co_wd[i]), .rdata(ci[i]));
	end
	initial begin
		core_clk = 1'b0;
		forever begin
			#5 core_clk = ~core_clk;
		end
	end
	// one port active at a time
	task automatic op(input int p, input logic w, c, k, e,
		input logic [9:0] a, input logic [35:0] d, x);
		logic [35:0] early;
		@(posedge core_clk);
		en[p] <= 1'b1;
		we[p] <= w;
		cs[p] <= c;
		ad[p] <= a;
		wd[p] <= d;
		@(posedge core_clk);
		en[p] <= 1'b0;
		@(posedge core_clk);
		#1;
		early = rd[p];
		@(posedge core_clk);
		#1;
		if (k) begin
			checked++;
			if (rd[p] !== x || (e && early === x)) begin
				fail_count++;
				$display("CHECK FAILED at %0t: port %0d data", $time, p);
			end
		end
	endtask
	task automatic sc_share();
		op(0, 1, 0, 0, 0, X, 36'hA5A5A5A5A, 36'h0);
		op(1, 0, 0, 1, 1, X, 36'h0, 36'hA5A5A5A5A);
		op(0, 1, 0, 1, 0, X, 36'h5A5A5A5A5, 36'hA5A5A5A5A);
		op(1, 1, 0, 1, 1, 10'h155, 36'h0F0F0F0F0, 36'h0F0F0F0F0);
	endtask
	task automatic sc_cascade();
		op(0, 1, 1, 0, 0, X, 36'hF0F0F0F0F, 36'h0);
		op(0, 0, 0, 1, 0, X, 36'h0, 36'h5A5A5A5A5);
		op(0, 0, 1, 1, 1, X, 36'h0, 36'hF0F0F0F0F);
		op(1, 1, 1, 0, 0, 10'h0, 36'h123456789, 36'h0);
		op(1, 0, 1, 1, 1, 10'h0, 36'h0, 36'h123456789);
	endtask
	task automatic sc_gate();
		@(posedge core_clk);
		power_gate <= 1'b1;
		op(1, 1, 0, 1, 0, X, 36'h3C3C3C3C3, 36'h123456789);
		op(0, 0, 0, 1, 0, X, 36'h0, 36'hF0F0F0F0F);
		@(posedge core_clk);
		power_gate <= 1'b0;
		op(1, 0, 0, 1, 1, X, 36'h0, 36'h5A5A5A5A5);
	endtask
	task automatic final_report();
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		{rstn, power_gate, en, we, cs} = '0;
		ad = '{2{10'h0}};
		wd = '{2{36'h0}};
		fail_count = 0;
		checked = 0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		sc_share();
		sc_cascade();
		sc_gate();
		final_report();
	end
endmodule
